// File: sps_pkg.sv
// Constants and types shared by the strobe phase-shift block
package sps_pkg;
   localparam int NSTB = 18;
   localparam int SETW = 6;
   localparam int HISTW = 32;
   localparam int DLYW = 5;
   localparam int AW = 12;
   localparam int SHIFT_CNT = 36;
   typedef enum logic [1:0] {
      SPS_M0 = 2'b00,
      SPS_M1 = 2'b01,
      SPS_M2 = 2'b10,
      SPS_M3 = 2'b11
   } sps_mode_e;
   localparam logic [AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [AW-1:0] STAT_OFS = 12'h004;
   localparam logic [AW-1:0] CAPT_OFS = 12'h008;
   localparam logic [AW-1:0] CAPB_OFS = 12'h00c;
   localparam logic [AW-1:0] SHIFT_BASE = 12'h100;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0] SHIFT_RST = 3'h0;
   localparam logic [2:0] SHIFT_MAX = 3'h4;
   localparam int MODE_T_POS = 0;
   localparam int MODE_B_POS = 2;
   localparam int SLOW_T_POS = 4;
   localparam int SLOW_B_POS = 5;
   localparam int SEL_T_POS = 6;
   localparam int SEL_B_POS = 9;
   localparam int SRST_T_POS = 12;
   localparam int SRST_B_POS = 13;
   localparam int SET_T_POS = 0;
   localparam int SET_B_POS = 8;
   localparam int LOCK_T_POS = 16;
   localparam int LOCK_B_POS = 17;
   localparam int RDV_POS = 31;
   localparam logic [2:0] SEL_PLL = 3'h4;
   localparam logic [SETW-1:0] MAX_SET_M0 = 6'h3f;
   localparam logic [SETW-1:0] MAX_SET_M123 = 6'h1f;
   localparam logic [SETW-1:0] PER_SAT = 6'h3f;
   localparam logic [8:0] LOCK_REF_CYCLES = 9'h100;
   localparam logic [8:0] CHAINS_M02 = 9'h00c;
   localparam logic [8:0] CHAINS_M1 = 9'h010;
   localparam logic [8:0] CHAINS_M3 = 9'h00a;
   localparam int CLK_PERIOD_PS = 40000;
   localparam int SLOW_DELAY_PS = 2500;
   localparam int SLOW_CYC_I = (SLOW_DELAY_PS + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam logic [DLYW-1:0] SLOW_DLY_CYC =
      DLYW'(SLOW_CYC_I < 1 ? 1 : SLOW_CYC_I);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: sps_dll_if.sv
// Link between the register side and one delay-locked loop
`timescale 1ns/100ps
interface sps_dll_if;
   logic ref_lvl;
   logic rst_req;
   sps_pkg::sps_mode_e mode;
   logic [sps_pkg::SETW-1:0] setting;
   logic locked;
   modport ctl (output ref_lvl, rst_req, mode, input setting, locked);
   modport dll (input ref_lvl, rst_req, mode, output setting, locked);
endinterface

// File: sps_dll.sv
// Delay-locked loop: period tracking and lock wait for one side
`timescale 1ns/100ps
module sps_dll (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   sps_dll_if.dll lp
);
   logic ref_d_reg;
   logic [sps_pkg::SETW-1:0] per_reg;
   logic [sps_pkg::SETW-1:0] set_reg;
   logic [8:0] lck_reg;
   logic ref_rise;
   logic [sps_pkg::SETW-1:0] set_max;
   logic [sps_pkg::SETW-1:0] meas;

   assign ref_rise = lp.ref_lvl & ~ref_d_reg;
   // Mode 0 uses all six bits, the faster modes five
   assign set_max = (lp.mode == sps_pkg::SPS_M0) ?
      sps_pkg::MAX_SET_M0 : sps_pkg::MAX_SET_M123; // RULE15
   assign meas = (per_reg > set_max) ? set_max : per_reg;
   assign lp.setting = set_reg;
   assign lp.locked = (lck_reg == sps_pkg::LOCK_REF_CYCLES); // RULE21

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ref_d_reg <= 1'b0;
      else if (ce)
         ref_d_reg <= lp.ref_lvl;
   end

   // Reference period in system clocks, saturating
   always_ff @(posedge aclk)
   begin
      if (!aresetn || lp.rst_req)
         per_reg <= '0;
      else if (ce)
      begin
         if (ref_rise)
            per_reg <= 6'h01; // RULE9
         else if (per_reg != sps_pkg::PER_SAT)
            per_reg <= per_reg + 6'h01; // RULE10
      end
   end

   // Up/down counter, one step per reference edge; slow but glitch free
   always_ff @(posedge aclk)
   begin
      if (!aresetn || lp.rst_req)
         set_reg <= '0;
      else if (ce && ref_rise)
      begin
         if (set_reg < meas)
            set_reg <= set_reg + 6'h01; // RULE19
         else if (set_reg > meas)
            set_reg <= set_reg - 6'h01; // RULE19
      end
   end

   // Lock wait counted in reference cycles, restarted by any reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn || lp.rst_req)
         lck_reg <= '0; // RULE16
      else if (ce && ref_rise && !lp.locked)
         lck_reg <= lck_reg + 9'h001; // RULE11
   end

   chk_dll_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !lp.rst_req && !ref_rise |=> $stable(set_reg)) // RULE19
      else $error("setting moved without a reference edge");
   chk_dll_track: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !lp.rst_req && ref_rise && set_reg < meas
      |=> set_reg == $past(set_reg) + 6'h01) // RULE9
      else $error("setting did not step toward the period");
   chk_lock_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && lp.rst_req |=> !lp.locked && lck_reg == 9'h000) // RULE21
      else $error("lock survived a loop reset");
   chk_lock_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lp.locked) |-> $past(lck_reg) == 9'h0ff && $past(ref_rise))
      // RULE11
      else $error("lock rose before the reference count");
endmodule

// File: sps_top.sv
// Strobe phase shifter: register slave, two loops, strobe delay and capture
`timescale 1ns/100ps
// Behaviour
// RULE1: Two independent loops, one for the top side, one for the bottom.
// RULE2: Shifting and capture act only while the side reads.
// RULE3: Shift choices 0 to 144 degrees in the listed steps.
// RULE4: Each shifted strobe captures the data pin of its group.
// RULE5: Up to 18 strobes per side, own shift, one common loop setting.
// RULE6: Other party keeps one shift family per side.
// RULE7: Other party supplies a reference at the strobe frequency.
// RULE8: Reference from four side clock pins or that side's loop.
// RULE9: Loop keeps measuring the reference period and derives the delay.
// RULE10: Loop serves references from 100 to 400 MHz.
// RULE11: Up to 256 reference cycles to settle; data then unreliable.
// RULE12: Below 100 MHz a fixed 2.5 ns strobe delay applies; the slow bit here delays one 40 ns system clock instead.
// RULE13: Four frequency modes numbered 0 to 3 with their ranges.
// RULE14: Modes 0 and 2 use 12 chains, mode 1 16, mode 3 10.
// RULE15: Delay setting six bits in mode 0, five bits otherwise.
// RULE16: Loop reset from core or pin; 256 reference cycles wait after.
// RULE17: Memory drives read-valid high while returning read data.
// RULE18: Read-valid captured on its own pin by the shifted strobe.
// RULE19: Comparator steps an up/down counter holding a six-bit setting.
// RULE20: Zero-degree shift bypasses loop and delay logic.
// RULE21: Lock-ready rises after 256 reference cycles, clears on reset.
module sps_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [sps_pkg::AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [sps_pkg::AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [3:0] ref_top_pin,
   input wire logic ref_top_pll,
   input wire logic [3:0] ref_bot_pin,
   input wire logic ref_bot_pll,
   input wire logic dll_rst_pin,
   input wire logic core_dll_rst,
   input wire logic rd_active_top,
   input wire logic rd_active_bot,
   input wire logic [sps_pkg::NSTB-1:0] strobe_top,
   input wire logic [sps_pkg::NSTB-1:0] strobe_bot,
   input wire logic [sps_pkg::NSTB-1:0] data_top,
   input wire logic [sps_pkg::NSTB-1:0] data_bot,
   input wire logic read_valid_input_pin_top,
   input wire logic read_valid_input_pin_bot,
   output logic [sps_pkg::NSTB-1:0] shifted_strobe_top,
   output logic [sps_pkg::NSTB-1:0] shifted_strobe_bot,
   output logic [sps_pkg::NSTB-1:0] cap_data_top,
   output logic [sps_pkg::NSTB-1:0] cap_data_bot,
   output logic cap_rdvalid_top,
   output logic cap_rdvalid_bot,
   output logic locked_top,
   output logic locked_bot
);
   localparam int PINW = 4 * sps_pkg::NSTB + 13;

   logic [PINW-1:0] sync1_reg;
   logic [PINW-1:0] sync2_reg;
   logic [1:0][sps_pkg::NSTB-1:0] stb_s;
   logic [1:0][sps_pkg::NSTB-1:0] dat_s;
   logic [1:0][4:0] ref_s;
   logic [1:0] rdv_s;
   logic rst_pin_s;
   logic [1:0] rd_act;
   logic [31:0] ctrl_reg;
   logic [2:0] shift_mem [sps_pkg::SHIFT_CNT];
   logic [1:0][sps_pkg::SETW-1:0] set_w;
   logic [1:0] lock_w;
   logic [1:0][sps_pkg::NSTB-1:0] shf_w;
   logic [1:0][sps_pkg::NSTB-1:0] cap_w;
   logic [1:0][sps_pkg::NSTB-1:0] edge_w;
   logic [1:0] rdv_w;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [sps_pkg::AW-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic do_wr;
   logic wr_err;
   logic [31:0] rd_data;
   logic rd_err;

   function automatic logic shift_hit(input logic [sps_pkg::AW-1:0] a);
      shift_hit = a[sps_pkg::AW-1:8] == sps_pkg::SHIFT_BASE[sps_pkg::AW-1:8]
         && a[1:0] == 2'h0 && 32'(a[7:2]) < sps_pkg::SHIFT_CNT;
   endfunction

   function automatic logic ref_pick(input logic [4:0] r,
                                     input logic [2:0] sel);
      if (sel < sps_pkg::SEL_PLL)
         ref_pick = r[sel[1:0]]; // RULE8
      else if (sel == sps_pkg::SEL_PLL)
         ref_pick = r[4]; // RULE8
      else
         ref_pick = 1'b0;
   endfunction

   function automatic logic [8:0] chains_of(input sps_pkg::sps_mode_e m);
      unique case (m)
         sps_pkg::SPS_M1: chains_of = sps_pkg::CHAINS_M1; // RULE14
         sps_pkg::SPS_M3: chains_of = sps_pkg::CHAINS_M3; // RULE14
         sps_pkg::SPS_M0, sps_pkg::SPS_M2:
            chains_of = sps_pkg::CHAINS_M02; // RULE14
      endcase
   endfunction

   // Pins arrive asynchronously; second stage is the only reader of first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else if (ce)
      begin
         sync1_reg <= {dll_rst_pin, read_valid_input_pin_bot,
            read_valid_input_pin_top, ref_bot_pll, ref_bot_pin, ref_top_pll,
            ref_top_pin, data_bot, data_top, strobe_bot, strobe_top};
         sync2_reg <= sync1_reg;
      end
   end

   assign {rst_pin_s, rdv_s, ref_s, dat_s, stb_s} = sync2_reg;
   assign rd_act = {rd_active_bot, rd_active_top};

   // Register slave
   assign awready = ~aw_hold_reg;
   assign wready = ~w_hold_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = ~rvalid_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign do_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign wr_err = !(aw_addr_reg == sps_pkg::CTRL_OFS
      || shift_hit(aw_addr_reg));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
      end
      else if (ce)
      begin
         if (awvalid && !aw_hold_reg)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         else if (do_wr)
            aw_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end
      else if (ce)
      begin
         if (wvalid && !w_hold_reg)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         else if (do_wr)
            w_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= sps_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (do_wr)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_err ? sps_pkg::RESP_SLVERR : sps_pkg::RESP_OKAY;
         end
         else if (bready)
            bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_reg <= sps_pkg::CTRL_RST;
      else if (ce && do_wr && aw_addr_reg == sps_pkg::CTRL_OFS)
         for (int b = 0; b < 4; b++)
            if (w_strb_reg[b])
               ctrl_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
   end

   // Codes above the largest step saturate rather than alias
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int n = 0; n < sps_pkg::SHIFT_CNT; n++)
            shift_mem[n] <= sps_pkg::SHIFT_RST;
      end
      else if (ce && do_wr && shift_hit(aw_addr_reg) && w_strb_reg[0])
         shift_mem[aw_addr_reg[7:2]] <= (w_data_reg[2:0] > sps_pkg::SHIFT_MAX)
            ? sps_pkg::SHIFT_MAX : w_data_reg[2:0]; // RULE5
   end

   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (araddr == sps_pkg::CTRL_OFS)
         rd_data = ctrl_reg;
      else if (araddr == sps_pkg::STAT_OFS)
      begin
         rd_data[sps_pkg::SET_T_POS +: sps_pkg::SETW] = set_w[0];
         rd_data[sps_pkg::SET_B_POS +: sps_pkg::SETW] = set_w[1];
         rd_data[sps_pkg::LOCK_T_POS] = lock_w[0]; // RULE11
         rd_data[sps_pkg::LOCK_B_POS] = lock_w[1]; // RULE11
      end
      else if (araddr == sps_pkg::CAPT_OFS)
      begin
         rd_data[sps_pkg::NSTB-1:0] = cap_w[0];
         rd_data[sps_pkg::RDV_POS] = rdv_w[0];
      end
      else if (araddr == sps_pkg::CAPB_OFS)
      begin
         rd_data[sps_pkg::NSTB-1:0] = cap_w[1];
         rd_data[sps_pkg::RDV_POS] = rdv_w[1];
      end
      else if (shift_hit(araddr))
         rd_data[2:0] = shift_mem[araddr[7:2]];
      else
         rd_err = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= sps_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && !rvalid_reg)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_data;
            rresp_reg <= rd_err ? sps_pkg::RESP_SLVERR : sps_pkg::RESP_OKAY;
         end
         else if (rready)
            rvalid_reg <= 1'b0;
      end
   end

   // One loop per side; all strobes of a side share its setting
   for (genvar s = 0; s < 2; s++)
   begin : g_side
      localparam int MPOS = s == 0 ? sps_pkg::MODE_T_POS : sps_pkg::MODE_B_POS;
      localparam int SPOS = s == 0 ? sps_pkg::SEL_T_POS : sps_pkg::SEL_B_POS;
      localparam int RPOS = s == 0 ? sps_pkg::SRST_T_POS : sps_pkg::SRST_B_POS;
      localparam int LPOS = s == 0 ? sps_pkg::SLOW_T_POS : sps_pkg::SLOW_B_POS;
      logic slow;
      logic [8:0] chains;
      logic rdv_cap_reg;
      sps_dll_if dif ();

      assign dif.ref_lvl = ref_pick(ref_s[s], ctrl_reg[SPOS +: 3]); // RULE8
      assign dif.rst_req = rst_pin_s | core_dll_rst | ctrl_reg[RPOS]; // RULE16
      assign dif.mode = sps_pkg::sps_mode_e'(ctrl_reg[MPOS +: 2]); // RULE13
      assign slow = ctrl_reg[LPOS];
      assign chains = chains_of(dif.mode);
      assign set_w[s] = dif.setting;
      assign lock_w[s] = dif.locked;
      assign rdv_w[s] = rdv_cap_reg;

      sps_dll u_dll (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .lp(dif)
      ); // RULE1

      // Read-valid sampled like a data bit by the group 0 strobe
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            rdv_cap_reg <= 1'b0;
         else if (ce && edge_w[s][0])
            rdv_cap_reg <= rdv_s[s]; // RULE18
      end

      for (genvar i = 0; i < sps_pkg::NSTB; i++)
      begin : g_stb
         logic [2:0] k;
         logic [8:0] prod;
         logic [8:0] quo;
         logic [sps_pkg::DLYW-1:0] dly;
         logic dstb;
         logic [sps_pkg::HISTW-1:0] hist_reg;
         logic shf_reg;
         logic cap_reg;

         // Shift is k steps of one chain: 360 degrees over the chain count
         assign k = shift_mem[s * sps_pkg::NSTB + i]; // RULE3
         assign prod = {3'h0, set_w[s]} * {6'h00, k};
         assign quo = prod / chains; // RULE14
         assign dly = slow ? sps_pkg::SLOW_DLY_CYC
            : quo[sps_pkg::DLYW-1:0]; // RULE12
         assign dstb = (k == 3'h0 || dly == '0) ? stb_s[s][i]
            : hist_reg[dly - 5'h01]; // RULE20
         assign edge_w[s][i] = rd_act[s] & dstb & ~shf_reg;
         assign shf_w[s][i] = shf_reg;
         assign cap_w[s][i] = cap_reg;

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               hist_reg <= '0;
            else if (ce)
               hist_reg <= {hist_reg[sps_pkg::HISTW-2:0], stb_s[s][i]};
         end

         // Write cycles leave the strobe path quiet
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               shf_reg <= 1'b0;
            else if (ce)
               shf_reg <= rd_act[s] & dstb; // RULE2
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               cap_reg <= 1'b0;
            else if (ce && edge_w[s][i])
               cap_reg <= dat_s[s][i]; // RULE4
         end

         chk_idle_quiet: assert property (@(posedge aclk)
            disable iff (!aresetn)
            ce && !rd_act[s] |=> !shf_reg) // RULE2
            else $error("strobe path active outside a read");
         chk_bypass_zero: assert property (@(posedge aclk)
            disable iff (!aresetn)
            ce && rd_act[s] && k == 3'h0 |=> shf_reg == $past(stb_s[s][i]))
            // RULE20
            else $error("zero shift did not bypass the delay");
         chk_slow_fixed: assert property (@(posedge aclk)
            disable iff (!aresetn)
            slow && k != 3'h0 |-> dly == sps_pkg::SLOW_DLY_CYC) // RULE12
            else $error("slow mode delay is not the fixed value");
         chk_cap_edge: assert property (@(posedge aclk)
            disable iff (!aresetn)
            ce && edge_w[s][i] |=> cap_reg == $past(dat_s[s][i])) // RULE4
            else $error("data not taken on the shifted strobe edge");
      end
   end

   assign shifted_strobe_top = shf_w[0];
   assign shifted_strobe_bot = shf_w[1];
   assign cap_data_top = cap_w[0];
   assign cap_data_bot = cap_w[1];
   assign cap_rdvalid_top = rdv_w[0];
   assign cap_rdvalid_bot = rdv_w[1];
   assign locked_top = lock_w[0]; // RULE21
   assign locked_bot = lock_w[1]; // RULE21
endmodule

// File: sps_mem_model.sv
// Memory model: read bursts of strobe, data and read-valid
`timescale 1ns/100ps
module sps_mem_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [sps_pkg::NSTB-1:0] pat,
   output logic [sps_pkg::NSTB-1:0] strobe,
   output logic [sps_pkg::NSTB-1:0] dq,
   output logic rdv
);
   logic act = 1'b0;
   // Strobe follows the reference, still between bursts
   assign strobe = {sps_pkg::NSTB{act & ref_clk}};
   initial
   begin
      dq = '0;
      rdv = 1'b0;
   end
   always @(posedge go)
   begin
      @(posedge ref_clk);
      rdv = 1'b1;
      @(negedge ref_clk);
      dq = pat;
      act = 1'b1;
      repeat (4) @(negedge ref_clk);
      act = 1'b0;
      // Hold past the last delayed capture, then show a changed value
      repeat (2) @(negedge ref_clk);
      rdv = 1'b0;
      dq = ~pat;
   end
endmodule

// File: test_sps_top.sv
// Self-checking bench for the strobe phase shifter
`timescale 1ns/100ps
module test_sps_top;
   localparam logic [1:0] OK = sps_pkg::RESP_OKAY;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, ref_clk = 1'b0;
   logic [sps_pkg::AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, go = 1'b0, leak = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, rdv_t, rdv_b;
   logic [1:0] bresp, rresp;
   logic dll_rst_pin = 1'b0, core_dll_rst = 1'b0;
   logic rd_act_t = 1'b0, rd_act_b = 1'b0, gate_chk = 1'b0;
   logic [17:0] pat = '0, stb_t, stb_b, dq_t, dq_b, sh_t, sh_b, cd_t, cd_b;
   logic crv_t, crv_b, lk_t, lk_b, prev_s = 1'b0, prev_o = 1'b0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int lat_q[$];
   int failures = 0, n_compared = 0, cyc = 0, cnt = 0, l0 = -1, meas = 0;
   int ch[4] = '{12, 16, 12, 10};
   initial
   begin
      forever #20 aclk = ~aclk;
   end
   // Odd offset puts every reference edge 7 ns before an aclk rising edge
   initial
   begin
      #13;
      forever #160 ref_clk = ~ref_clk;
   end
   sps_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .ref_top_pin({3'h0, ref_clk}), .ref_top_pll(1'b0),
      .ref_bot_pin(4'h0), .ref_bot_pll(ref_clk), .dll_rst_pin(dll_rst_pin),
      .core_dll_rst(core_dll_rst), .rd_active_top(rd_act_t),
      .rd_active_bot(rd_act_b), .strobe_top(stb_t), .strobe_bot(stb_b),
      .data_top(dq_t), .data_bot(dq_b), .read_valid_input_pin_top(rdv_t),
      .read_valid_input_pin_bot(rdv_b), .shifted_strobe_top(sh_t),
      .shifted_strobe_bot(sh_b), .cap_data_top(cd_t), .cap_data_bot(cd_b),
      .cap_rdvalid_top(crv_t), .cap_rdvalid_bot(crv_b), .locked_top(lk_t),
      .locked_bot(lk_b));
   sps_mem_model mem_t (.ref_clk(ref_clk), .go(go), .pat(pat),
      .strobe(stb_t), .dq(dq_t), .rdv(rdv_t));
   sps_mem_model mem_b (.ref_clk(ref_clk), .go(go), .pat(~pat),
      .strobe(stb_b), .dq(dq_b), .rdv(rdv_b));
   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic give_verdict;
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic burst;
      @(posedge aclk);
      pat <= 18'($urandom);
      go <= 1'b1;
      @(negedge rdv_t);
      @(posedge aclk);
      go <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic lock_is(input logic [1:0] e, input int n);
      repeat (n) @(posedge aclk);
      cmp({32'h0, lk_t, lk_b}, {32'h0, e});
   endtask
   // Monitor: handshakes and strobe latency against the noted results
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         failures++;
         give_verdict;
      end
      if (rvalid && rready && rq.size() > 0)
         cmp({rresp, rdata}, rq.pop_front());
      if (bvalid && bready && bq.size() > 0)
         cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (gate_chk && sh_t != '0)
         leak = 1'b1;
      prev_s <= stb_t[0];
      prev_o <= sh_t[0];
      cnt <= (stb_t[0] && !prev_s) ? 0 : cnt + 1;
      if (meas != 0 && sh_t[0] && !prev_o)
      begin
         meas = 0;
         if (l0 < 0)
            l0 = cnt;
         else
            cmp(34'(cnt), 34'(l0 + lat_q.pop_front()));
      end
   end
   initial
   begin
      void'($urandom(21118));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(sps_pkg::CTRL_OFS, {OK, sps_pkg::CTRL_RST});
      rd(sps_pkg::SHIFT_BASE + 12'h004, {OK, 32'h0});
      rd(12'h080, {sps_pkg::RESP_SLVERR, 32'h0});
      wr(12'h082, 32'h1, sps_pkg::RESP_SLVERR);
      wr(sps_pkg::SHIFT_BASE, 32'h7, OK);
      rd(sps_pkg::SHIFT_BASE, {OK, 32'h4});
      // Bottom still selects a silent pin, so only the top locks
      lock_is(2'b10, 2300);
      wr(sps_pkg::CTRL_OFS, 32'h800, OK);
      lock_is(2'b11, 2300);
      rd(sps_pkg::STAT_OFS, {OK, 32'h0003_0808});
      wr(sps_pkg::CTRL_OFS, 32'h2800, OK);
      lock_is(2'b10, 3);
      wr(sps_pkg::CTRL_OFS, 32'h800, OK);
      core_dll_rst <= 1'b1;
      lock_is(2'b00, 3);
      core_dll_rst <= 1'b0;
      lock_is(2'b00, 1900);
      lock_is(2'b11, 400);
      dll_rst_pin <= 1'b1;
      lock_is(2'b00, 5);
      dll_rst_pin <= 1'b0;
      lock_is(2'b11, 2300);
      rd_act_t <= 1'b1;
      rd_act_b <= 1'b1;
      // Each shift code on top strobe 0, in each top-side mode
      for (int m = 0; m < 4; m++)
         for (int k = 0; k < 5; k++)
         begin
            wr(sps_pkg::CTRL_OFS, 32'h800 | 32'(m), OK);
            wr(sps_pkg::SHIFT_BASE, 32'(k), OK);
            if (m != 0 || k != 0)
               lat_q.push_back((8 * k) / ch[m]);
            meas = 1;
            burst;
            rd(sps_pkg::CAPT_OFS, {OK, 1'b1, 13'h0, pat});
            cmp({15'h0, crv_t, cd_t}, {15'h0, 1'b1, pat});
         end
      rd(sps_pkg::CAPB_OFS, {OK, 1'b1, 13'h0, ~pat});
      wr(sps_pkg::CTRL_OFS, 32'h810, OK);
      wr(sps_pkg::SHIFT_BASE, 32'h2, OK);
      lat_q.push_back(1);
      meas = 1;
      burst;
      rd_act_t <= 1'b0;
      repeat (8) @(posedge aclk);
      gate_chk = 1'b1;
      burst;
      gate_chk = 1'b0;
      cmp({33'h0, leak}, 34'h0);
      rd(sps_pkg::CAPB_OFS, {OK, 1'b1, 13'h0, ~pat});
      cmp({15'h0, crv_b, cd_b}, {15'h0, 1'b1, ~pat});
      give_verdict;
   end
endmodule
